// File: inc/np_rx_consts.svh
// Constants for the next-page receive register bank.
// Assumes inclusion by bare name from the design, checker and testbench files.
//
// How it works
// - Writable 11-bit transmit code field, resets 1
// - Selected byte appears in indirect data byte
// - Bit 15 reports partner more pages follow
// - Bit 14 acknowledge, set after three consistent bursts
// - Bit 13 reports partner message page flag
// - Bit 12 reports partner will comply flag
// - Toggle bit inverts previous codeword toggle
// - First toggle inverts base codeword bit 11
`ifndef NP_RX_CONSTS_SVH
`define NP_RX_CONSTS_SVH
`define REG_IND_CTRL 8'h6e
`define REG_IND_OFS 8'h6f
`define REG_IND_DATA 8'ha0
`define TABLE_EEE 3'h1
`define OFS_TX_HI 8'h0e
`define OFS_TX_LO 8'h0f
`define OFS_RX_HI 8'h10
`define OFS_RX_LO 8'h11
`define CODE_RESET 11'h001
`define BIT_MORE 15
`define BIT_ACK 14
`define BIT_MSG 13
`define BIT_COMPLY 12
`define BIT_TOGGLE 11
`define ACK_BURSTS 2'h3
`endif

// File: inc/np_rx_pkg.sv
// Types for the next-page receive register bank.
// Assumes nothing beyond the constants header.
package np_rx_pkg;
  typedef logic [15:0] codeword_t;
  typedef logic [3:0] port_t;
endpackage

// File: core/np_rx_regs.sv
// Next-page receive registers per port, reached by indirect byte access.
// Assumes a byte register port and per-port page capture strobes.
`timescale 1ns/1ps
`default_nettype none
`include "np_rx_consts.svh"
module np_rx_regs
  import np_rx_pkg::*;
#(
  parameter int NPORTS = 3
) (
  input wire logic CORE_CLK, // System clock
  input wire logic ARST_N, // Async reset
  input wire logic REG_WR, // Byte register write strobe
  input wire logic [7:0] REG_ADDR, // Byte register address
  input wire logic [7:0] REG_WDATA, // Write data
  output logic [7:0] REG_RDATA, // Read data
  input wire logic [NPORTS-1:0] PAGE_VALID, // Codeword burst from partner, per port
  input wire logic [16*NPORTS-1:0] PAGE_WORD, // Received codewords
  input wire logic [NPORTS-1:0] BASE_TOGGLE, // Base codeword bit 11 per port
  output logic [11*NPORTS-1:0] TX_CODE // Local transmit code field
);
  // Port number field is four bits and port 0 is not addressable
  if (NPORTS < 1 || NPORTS > 15) begin : g_bad_nports
    $error("NPORTS out of range");
  end

  logic [7:0] ctrl_q;
  logic [7:0] ofs_q;
  logic [7:0] rdata_q;
  codeword_t rx_q [NPORTS];
  logic [10:0] code_q [NPORTS];
  logic [1:0] cnt_q [NPORTS];
  codeword_t last_q [NPORTS];
  logic tog_q [NPORTS];
  logic first_q [NPORTS];

  function automatic logic sel_port(input logic [7:0] c, input int p);
    sel_port = (c[7:5] == `TABLE_EEE) && (c[3:0] == 4'(p + 1));
  endfunction

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= 8'h00;
      ofs_q <= 8'h00;
    end else if (REG_WR) begin
      if (REG_ADDR == `REG_IND_CTRL) begin
        ctrl_q <= REG_WDATA;
      end else if (REG_ADDR == `REG_IND_OFS) begin
        ofs_q <= REG_WDATA;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      codeword_t w;
      assign w = PAGE_WORD[16*g +: 16];
      assign TX_CODE[11*g +: 11] = code_q[g];

      // Writes through the data byte reach only the code field
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          code_q[g] <= `CODE_RESET;
        end else if (REG_WR && REG_ADDR == `REG_IND_DATA && sel_port(ctrl_q, g)) begin
          if (ofs_q == `OFS_TX_HI) begin
            code_q[g][10:8] <= REG_WDATA[2:0];
          end else if (ofs_q == `OFS_TX_LO) begin
            code_q[g][7:0] <= REG_WDATA;
          end
        end
      end

      // Consistency count over successive bursts
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          cnt_q[g] <= 2'h0;
          last_q[g] <= 16'h0000;
        end else if (PAGE_VALID[g]) begin
          last_q[g] <= w;
          // Ack bit excluded from comparison
          if ({w[15], w[13:0]} == {last_q[g][15], last_q[g][13:0]}) begin
            if (cnt_q[g] != `ACK_BURSTS) cnt_q[g] <= cnt_q[g] + 2'h1;
          end else begin
            cnt_q[g] <= 2'h1;
          end
        end
      end

      // Capture once three matching bursts seen; host writes never touch it
      always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          rx_q[g] <= 16'h0000;
          tog_q[g] <= 1'b0;
          first_q[g] <= 1'b1;
        end else if (PAGE_VALID[g] && cnt_q[g] >= 2'h2 &&
                     {w[15], w[13:0]} == {last_q[g][15], last_q[g][13:0]}) begin
          rx_q[g][`BIT_MORE] <= w[`BIT_MORE];
          rx_q[g][`BIT_ACK] <= 1'b1;
          rx_q[g][`BIT_MSG] <= w[`BIT_MSG];
          rx_q[g][`BIT_COMPLY] <= w[`BIT_COMPLY];
          // Expected toggle: inverse of previous, first from base page
          rx_q[g][`BIT_TOGGLE] <= first_q[g] ? ~BASE_TOGGLE[g] : ~tog_q[g];
          tog_q[g] <= first_q[g] ? ~BASE_TOGGLE[g] : ~tog_q[g];
          first_q[g] <= 1'b0;
          rx_q[g][10:0] <= w[10:0];
        end
      end
    end
  endgenerate

  // Registered read path; unmapped reads return zero
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (REG_ADDR == `REG_IND_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (REG_ADDR == `REG_IND_OFS) begin
        rdata_q <= ofs_q;
      end else if (REG_ADDR == `REG_IND_DATA) begin
        for (int p = 0; p < NPORTS; p++) begin
          if (sel_port(ctrl_q, p)) begin
            if (ofs_q == `OFS_RX_HI) rdata_q <= rx_q[p][15:8];
            else if (ofs_q == `OFS_RX_LO) rdata_q <= rx_q[p][7:0];
            else if (ofs_q == `OFS_TX_HI) rdata_q <= {5'h00, code_q[p][10:8]};
            else if (ofs_q == `OFS_TX_LO) rdata_q <= code_q[p][7:0];
          end
        end
      end
    end
  end

  assign REG_RDATA = rdata_q;
endmodule
`default_nettype wire

// File: dv/np_rx_regs_chk.sv
// Checker on the register bank ports.
// Assumes binding into np_rx_regs.
`timescale 1ns/1ps
`default_nettype none
`include "np_rx_consts.svh"
module np_rx_regs_chk #(parameter int NPORTS = 3) (
  input wire logic CORE_CLK, ARST_N, REG_WR,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input wire logic [NPORTS-1:0] PAGE_VALID,
  input wire logic [11*NPORTS-1:0] TX_CODE);
  logic [7:0] ctl_q, ofs_q;
  logic da, dw;
  int p;
  always_ff @(posedge CORE_CLK or negedge ARST_N)
    if (!ARST_N) {ctl_q, ofs_q} <= 16'h0000;
    else if (REG_WR && REG_ADDR == `REG_IND_CTRL) ctl_q <= REG_WDATA;
    else if (REG_WR && REG_ADDR == `REG_IND_OFS) ofs_q <= REG_WDATA;
  assign p = 11 * (int'(ctl_q[3:0]) - 1);
  assign da = REG_ADDR == `REG_IND_DATA && ctl_q[7:5] == `TABLE_EEE && p >= 0 && p < 11 * NPORTS;
  assign dw = REG_WR && da;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  a_tx_reset_one: assert property ($rose(ARST_N) |-> TX_CODE == {NPORTS{`CODE_RESET}})
    else $error("tx reset");
  a_rd_reset_zero: assert property ($rose(ARST_N) |-> REG_RDATA == 8'h00)
    else $error("rdata reset");
  a_tx_hold: assert property (!(dw && ofs_q[7:1] == 7'h07) |=> $stable(TX_CODE))
    else $error("tx changed");
  a_tx_lo_wr: assert property (dw && ofs_q == `OFS_TX_LO |=> TX_CODE[p+:8] == $past(REG_WDATA))
    else $error("tx lo");
  a_tx_hi_wr: assert property (dw && ofs_q == `OFS_TX_HI |=> TX_CODE[p+8+:3] == $past(REG_WDATA[2:0]))
    else $error("tx hi");
  a_tx_lo_rd: assert property (da && !REG_WR && ofs_q == `OFS_TX_LO |=> REG_RDATA == $past(TX_CODE[p+:8]))
    else $error("tx read");
  a_unmapped_zero: assert property (!(REG_ADDR inside {8'h6e, 8'h6f, 8'ha0}) |=> REG_RDATA == 8'h00)
    else $error("unmapped");
  a_rd_hold: assert property ($stable(REG_ADDR) && !$past(REG_WR) && $past(PAGE_VALID) == '0 |=> $stable(REG_RDATA))
    else $error("rdata moved");
endmodule
bind np_rx_regs np_rx_regs_chk #(.NPORTS(NPORTS)) np_rx_regs_chk_inst (.CORE_CLK, .ARST_N, .REG_WR,
  .REG_ADDR, .REG_WDATA, .REG_RDATA, .PAGE_VALID, .TX_CODE);
`default_nettype wire

// File: dv/np_rx_partner.sv
// Link partner model sending codeword bursts.
// Assumes three ports, index 0 is port 1.
`timescale 1ns/1ps
`default_nettype none
module np_rx_partner (
  input wire logic clk, // System clock
  output logic [2:0] vld = 3'h0, // Burst strobes
  output logic [47:0] word = '0); // Codewords
  // Line inverted between bursts so stale data never looks valid
  task automatic burst(input int i, input logic [15:0] w, input int n);
    repeat (n) begin
      @(posedge clk); #1; vld[i] = 1'b1; word[16*i+:16] = w;
      @(posedge clk); #1; vld[i] = 1'b0; word[16*i+:16] = ~w;
    end
  endtask
endmodule
`default_nettype wire

// File: dv/np_rx_regs_tb_top.sv
// Testbench for the next-page register bank.
// Assumes the partner model drives the capture inputs.
`timescale 1ns/1ps
`default_nettype none
`include "np_rx_consts.svh"
module np_rx_regs_tb_top;
  logic CORE_CLK = 1'b0, ARST_N = 1'b0, REG_WR = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [2:0] PAGE_VALID, BASE_TOGGLE = 3'h0;
  logic [47:0] PAGE_WORD;
  logic [32:0] TX_CODE;
  int fails = 0, num_checks = 0;
  always #5 CORE_CLK = ~CORE_CLK;
  np_rx_regs np_rx_regs_inst (.CORE_CLK, .ARST_N, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .PAGE_VALID, .PAGE_WORD, .BASE_TOGGLE, .TX_CODE);
  np_rx_partner np_rx_partner_inst (.clk(CORE_CLK), .vld(PAGE_VALID), .word(PAGE_WORD));
  task automatic chk(input logic [10:0] g, e);
    num_checks++;
    if (g !== e) begin fails++; $display("mismatch %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge CORE_CLK); #1; REG_WR = 1'b1; REG_ADDR = a; REG_WDATA = d;
    @(posedge CORE_CLK); #1; REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [3:0] pt, input logic [7:0] o, e);
    wr(`REG_IND_CTRL, {`TABLE_EEE, 1'b0, pt});
    wr(`REG_IND_OFS, o);
    REG_ADDR = `REG_IND_DATA;
    @(posedge CORE_CLK); #1; chk({3'h0, REG_RDATA}, {3'h0, e});
  endtask
  task automatic t_tx;
    rd(4'h1, `OFS_TX_LO, 8'h01);
    rd(4'h2, `OFS_TX_HI, 8'h00);
    wr(`REG_IND_DATA, 8'hff);
    rd(4'h2, `OFS_TX_HI, 8'h07);
    chk(TX_CODE[21:11], 11'h701);
    rd(4'h2, `OFS_RX_LO, 8'h00);
    wr(`REG_IND_DATA, 8'h5a);
    rd(4'h2, `OFS_RX_LO, 8'h00);
  endtask
  task automatic t_capture;
    np_rx_partner_inst.burst(2, 16'hb5a3, 2);
    rd(4'h3, `OFS_RX_HI, 8'h00);
    np_rx_partner_inst.burst(2, 16'hb5a3, 1);
    rd(4'h3, `OFS_RX_HI, 8'hfd);
    rd(4'h3, `OFS_RX_LO, 8'ha3);
    np_rx_partner_inst.burst(2, 16'h25a3, 3);
    rd(4'h3, `OFS_RX_HI, 8'h65);
    BASE_TOGGLE = 3'h1;
    np_rx_partner_inst.burst(0, 16'h0000, 3);
    rd(4'h1, `OFS_RX_HI, 8'h40);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    #1; ARST_N = 1'b1;
    t_tx;
    t_capture;
    end_sim;
  end
  initial begin #100000; fails++; end_sim; end
endmodule
`default_nettype wire
